// File: hw/irf_regs.sv
// interrupt flag and reset cause register bank with axi4-lite slave
`timescale 1ns/10ps
// ****************************************
// What this block does
// - flags set regardless of any enable
// - bit 7 sets on eeprom write done
// - bit 6 sets on comparator output change
// - bit 4 mirrors tx empty, read-only
// - capture mode: bit 2 sets on capture
// - compare mode sets bit 2; pwm none
// - bit 0 sets on 16-bit timer overflow
// - reset cause bits 7-4, 2 read zero
// - bit 3 selects fast/slow, resets one
// - resistor mode: select uses external resistor
// - power-on reset clears bits 1 and 0
// - brown-out reset clears bit 0 only
// - brown-out bit zero after power-on
// - brown-out bit meaningless when detector off
// ****************************************
module irf_regs (
  // clock and power-on reset
  input wire logic clock_i,
  input wire logic rst_i,
  // other resets from the reset controller, one-cycle pulses
  input wire logic brownout_rst_i,
  input wire logic other_rst_i,
  // configuration levels
  input wire logic brownout_detector_enable_i,
  input wire logic resistor_osc_mode_i,
  input wire logic [1:0] capcmp_mode_i,
  // peripheral events, one-cycle pulses on this clock
  input wire logic eeprom_write_done_i,
  input wire logic capture_event_i,
  input wire logic compare_match_i,
  input wire logic period_match_i,
  input wire logic timer16_overflow_i,
  // peripheral levels on this clock
  input wire logic serial_rx_full_i,
  input wire logic serial_tx_empty_i,
  // comparator outputs, asynchronous
  input wire logic [1:0] cmp_out_i,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // outputs to the oscillator and interrupt logic
  output logic osc_fast_o,
  output logic osc_use_resistor_o,
  output logic irq_o
);

  // ****************************************
  // state
  // ****************************************
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [7:0] flags_ff, nxt_flags;
  logic osc_freq_ff, nxt_osc_freq;
  logic por_ff, nxt_por;
  logic bod_ff, nxt_bod;
  logic [7:0] irq_stat_ff, nxt_irq_stat;
  logic [7:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  logic osc_res_ff, nxt_osc_res;
  logic rx_prev_ff, tx_prev_ff;
  logic [irf_pkg::SYNC_STAGES-1:0] cmp_sync_ff [irf_pkg::CMP_COUNT];
  logic [irf_pkg::CMP_COUNT-1:0] cmp_stable_ff, nxt_cmp_stable;

  // ****************************************
  // combinational helpers
  // ****************************************
  logic do_write;
  logic ar_take;
  logic cmp_change;
  logic [7:0] hw_set;
  logic [7:0] flags_view;
  logic [7:0] rcause_view;
  logic [7:0] events;
  logic [7:0] rd_byte;
  logic rd_hit;

  // ****************************************
  // comparator synchronisers
  // ****************************************

  // three stages; only stages two and three are looked at
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < irf_pkg::CMP_COUNT; i++) begin
        cmp_sync_ff[i] <= '0;
      end
      cmp_stable_ff <= '0;
    end else begin
      for (int i = 0; i < irf_pkg::CMP_COUNT; i++) begin
        cmp_sync_ff[i] <= {cmp_sync_ff[i][1:0], cmp_out_i[i]};
      end
      cmp_stable_ff <= nxt_cmp_stable;
    end
  end

  always_comb begin
    nxt_cmp_stable = cmp_stable_ff;
    cmp_change = 1'b0;
    for (int i = 0; i < irf_pkg::CMP_COUNT; i++) begin
      if (cmp_sync_ff[i][1] == cmp_sync_ff[i][2] && cmp_sync_ff[i][2] != cmp_stable_ff[i]) begin
        nxt_cmp_stable[i] = cmp_sync_ff[i][2];
        cmp_change = 1'b1;
      end
    end
  end

  // ****************************************
  // hardware set terms and read views
  // ****************************************

  always_comb begin
    hw_set = 8'h00;
    hw_set[irf_pkg::BIT_EEPROM_DONE] = eeprom_write_done_i;
    hw_set[irf_pkg::BIT_CMP_CHANGE] = cmp_change;
    // match in compare mode; pwm ignored
    hw_set[irf_pkg::BIT_CAPCMP] = (capture_event_i && capcmp_mode_i == irf_pkg::MODE_CAPTURE) ||
                                  (compare_match_i && capcmp_mode_i == irf_pkg::MODE_COMPARE);
    hw_set[irf_pkg::BIT_PERIOD_MATCH] = period_match_i;
    hw_set[irf_pkg::BIT_T16_OVF] = timer16_overflow_i;
  end

  // live buffer levels replace the stored bits 5 and 4
  always_comb begin
    flags_view = flags_ff & irf_pkg::FLAGS_WR_MASK;
    flags_view[irf_pkg::BIT_RX_FULL] = serial_rx_full_i;
    flags_view[irf_pkg::BIT_TX_EMPTY] = serial_tx_empty_i;
    rcause_view = 8'h00;
    rcause_view[irf_pkg::BIT_OSC_FREQ] = osc_freq_ff;
    rcause_view[irf_pkg::BIT_POR] = por_ff;
    rcause_view[irf_pkg::BIT_BOD] = bod_ff;
  end

  // interrupt events: flag sets plus buffer level rising edges
  always_comb begin
    events = hw_set;
    events[irf_pkg::BIT_RX_FULL] = serial_rx_full_i & ~rx_prev_ff;
    events[irf_pkg::BIT_TX_EMPTY] = serial_tx_empty_i & ~tx_prev_ff;
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

  // address and data taken in either order, answer after both
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      if (waddr_ff == irf_pkg::ADDR_FLAGS || waddr_ff == irf_pkg::ADDR_RCAUSE ||
          waddr_ff == irf_pkg::ADDR_IRQ_STAT || waddr_ff == irf_pkg::ADDR_IRQ_MASK) begin
        nxt_bresp = irf_pkg::RESP_OKAY;
      end else begin
        nxt_bresp = irf_pkg::RESP_DECERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // one write in flight; ready drops while a half is held
    nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
    nxt_wready = ~nxt_w_held & ~nxt_bvalid;
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign ar_take = s_axi_arvalid & arready_ff;

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == irf_pkg::ADDR_FLAGS) begin
      rd_byte = flags_view;
    end else if (s_axi_araddr == irf_pkg::ADDR_RCAUSE) begin
      rd_byte = rcause_view;
    end else if (s_axi_araddr == irf_pkg::ADDR_IRQ_STAT) begin
      rd_byte = irq_stat_ff;
    end else if (s_axi_araddr == irf_pkg::ADDR_IRQ_MASK) begin
      rd_byte = irq_mask_ff;
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // answer one cycle after the address is taken
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_take) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = {24'h000000, rd_byte};
      nxt_rresp = rd_hit ? irf_pkg::RESP_OKAY : irf_pkg::RESP_DECERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = ~nxt_rvalid;
  end

  // ****************************************
  // register contents
  // ****************************************
  always_comb begin
    nxt_flags = flags_ff;
    nxt_osc_freq = osc_freq_ff;
    nxt_por = por_ff;
    nxt_bod = bod_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    // software writes; byte lane 0 carries every field
    if (do_write && wstrb0_ff) begin
      if (waddr_ff == irf_pkg::ADDR_FLAGS) begin
        // buffer bits masked off from writes
        nxt_flags = wdata_ff & irf_pkg::FLAGS_WR_MASK;
      end else if (waddr_ff == irf_pkg::ADDR_RCAUSE) begin
        // only bits 3, 1, 0 take writes
        nxt_osc_freq = wdata_ff[irf_pkg::BIT_OSC_FREQ];
        nxt_por = wdata_ff[irf_pkg::BIT_POR];
        nxt_bod = wdata_ff[irf_pkg::BIT_BOD];
      end else if (waddr_ff == irf_pkg::ADDR_IRQ_MASK) begin
        nxt_irq_mask = wdata_ff;
      end
    end
    // hardware set applied after software write
    nxt_flags = nxt_flags | hw_set;
    // read of status clears it, but a new event survives
    if (ar_take && s_axi_araddr == irf_pkg::ADDR_IRQ_STAT) begin
      nxt_irq_stat = 8'h00;
    end
    nxt_irq_stat = nxt_irq_stat | events;
    // non-power-on resets clear flags, set bit 3 back to one, keep bit 1
    if (brownout_rst_i || other_rst_i) begin
      nxt_flags = irf_pkg::FLAGS_RESET;
      nxt_osc_freq = irf_pkg::RESET_OSC_FREQ;
    end
    // detector off: bit just left as software wrote it
    if (brownout_rst_i && brownout_detector_enable_i) begin
      nxt_bod = irf_pkg::RESET_BOD;
    end
    nxt_osc_res = nxt_osc_freq & resistor_osc_mode_i;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  // ****************************************
  // registers; rst_i is the power-on reset
  // ****************************************

  // brown-out bit given zero at power-on
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= irf_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= irf_pkg::RESP_OKAY;
      flags_ff <= irf_pkg::FLAGS_RESET;
      osc_freq_ff <= irf_pkg::RESET_OSC_FREQ;
      por_ff <= irf_pkg::RESET_POR;
      bod_ff <= irf_pkg::RESET_BOD;
      irq_stat_ff <= 8'h00;
      irq_mask_ff <= 8'h00;
      irq_ff <= 1'b0;
      osc_res_ff <= 1'b0;
      rx_prev_ff <= 1'b0;
      tx_prev_ff <= 1'b1; // empty buffer is the idle level, no false edge
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      flags_ff <= nxt_flags;
      osc_freq_ff <= nxt_osc_freq;
      por_ff <= nxt_por;
      bod_ff <= nxt_bod;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      osc_res_ff <= nxt_osc_res;
      rx_prev_ff <= serial_rx_full_i;
      tx_prev_ff <= serial_tx_empty_i;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign osc_fast_o = osc_freq_ff;
  assign osc_use_resistor_o = osc_res_ff;
  assign irq_o = irq_ff;

endmodule

// File: hw/irf_pkg.sv
// constants for the interrupt flag and reset cause register bank
package irf_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_RCAUSE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ****************************************
  // flag register field positions
  // ****************************************
  localparam int BIT_EEPROM_DONE = 7;
  localparam int BIT_CMP_CHANGE = 6;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_PERIOD_MATCH = 1;
  localparam int BIT_T16_OVF = 0;
  // bits software may write in the flag register
  localparam logic [7:0] FLAGS_WR_MASK = 8'hc7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ****************************************
  // reset cause register field positions
  // ****************************************
  localparam int BIT_OSC_FREQ = 3;
  localparam int BIT_POR = 1;
  localparam int BIT_BOD = 0;
  localparam logic RESET_OSC_FREQ = 1'b1;
  localparam logic RESET_POR = 1'b0;
  localparam logic RESET_BOD = 1'b0;

  // ****************************************
  // capture/compare unit modes
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_COMPARE = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // ****************************************
  // bus answers and misc
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int CMP_COUNT = 2;
  localparam int SYNC_STAGES = 3;

endpackage

// File: verif/irf_regs_chk.sv
// port assertions for the flag and reset cause register bank
`timescale 1ns/10ps
module irf_regs_chk (
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic brownout_rst_i,
  input wire logic other_rst_i,
  // levels
  input wire logic resistor_osc_mode_i,
  input wire logic serial_rx_full_i,
  input wire logic serial_tx_empty_i,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // oscillator outputs
  input wire logic osc_fast_o,
  input wire logic osc_use_resistor_o
);
  // ****************************************
  // read and write steps
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_rd_flags;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == irf_pkg::ADDR_FLAGS;
  endsequence
  sequence s_rd_cause;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == irf_pkg::ADDR_RCAUSE;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ****************************************
  // checks
  // ****************************************
  a_cause_unused: assert property (s_rd_cause |=> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[2])
    else $error("reset cause unused bits not zero");
  a_flag_gap: assert property (s_rd_flags |=> s_axi_rdata[3] == 1'b0)
    else $error("flag bit 3 not zero");
  // live bits only judged when the level held still, so either sampling point agrees
  a_live_bits: assert property ((s_rd_flags ##0 ($stable(serial_tx_empty_i) && $stable(serial_rx_full_i)))
    |=> s_axi_rdata[5:4] == $past({serial_rx_full_i, serial_tx_empty_i})) else $error("live flag bits wrong");
  a_osc_soft: assert property ((brownout_rst_i || other_rst_i) |-> ##[1:2] osc_fast_o)
    else $error("freq select not back to one");
  a_osc_por: assert property ($fell(rst_i) |-> osc_fast_o)
    else $error("freq select low after power-on");
  a_res_on: assert property ((resistor_osc_mode_i && osc_fast_o) [*3] |-> osc_use_resistor_o)
    else $error("resistor select missing");
  a_res_off: assert property (!resistor_osc_mode_i ##1 !resistor_osc_mode_i |-> !osc_use_resistor_o)
    else $error("resistor select outside resistor mode");
  a_wr_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind irf_regs irf_regs_chk irf_regs_chk_inst (.*);

// File: verif/tb_irf_regs.sv
// self-checking bench for the flag and reset cause register bank
`timescale 1ns/10ps
module tb_irf_regs;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clock_i = 1'b0, rst_i = 1'b1, brownout_rst_i = 1'b0, other_rst_i = 1'b0;
  logic brownout_detector_enable_i = 1'b1, resistor_osc_mode_i = 1'b0;
  logic [1:0] capcmp_mode_i = 2'h0, cmp_out_i = 2'h0;
  logic eeprom_write_done_i = 1'b0, capture_event_i = 1'b0, compare_match_i = 1'b0;
  logic period_match_i = 1'b0, timer16_overflow_i = 1'b0;
  logic serial_rx_full_i = 1'b0, serial_tx_empty_i = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic osc_fast_o, osc_use_resistor_o, irq_o;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  // event table: flag expected and unit mode per event
  logic [7:0] ex_tab [9] = '{8'h80, 8'h40, 8'h40, 8'h04, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00};
  logic [1:0] md_tab [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3};

  irf_regs irf_regs_inst (.*);

  always #2 clock_i = ~clock_i;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // readiness sampled mid-cycle so the taking edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = irf_pkg::RESP_OKAY);
    bit da = 0;
    bit dw = 0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clock_i);
      da |= s_axi_awready;
      dw |= s_axi_wready;
      @(posedge clock_i);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(negedge clock_i); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, e});
    @(posedge clock_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                        input logic [1:0] er = irf_pkg::RESP_OKAY);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clock_i); while (s_axi_arready !== 1'b1);
    @(posedge clock_i);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge clock_i); while (s_axi_rvalid !== 1'b1);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    chk(s_axi_rdata & m, e);
    @(posedge clock_i);
    s_axi_rready <= 1'b0;
  endtask
  task automatic fire(input int k);
    @(posedge clock_i);
    case (k)
      0: eeprom_write_done_i <= 1'b1;
      1: cmp_out_i[0] <= ~cmp_out_i[0];
      2: cmp_out_i[1] <= ~cmp_out_i[1];
      3, 7: capture_event_i <= 1'b1;
      4, 8: compare_match_i <= 1'b1;
      5: period_match_i <= 1'b1;
      default: timer16_overflow_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {eeprom_write_done_i, capture_event_i, compare_match_i, period_match_i, timer16_overflow_i} <= 5'h00;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic pulse_rst(input bit bo);
    @(posedge clock_i);
    if (bo) brownout_rst_i <= 1'b1;
    else other_rst_i <= 1'b1;
    @(posedge clock_i);
    {brownout_rst_i, other_rst_i} <= 2'h0;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h10);
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h08);
    rd_chk(irf_pkg::ADDR_IRQ_MASK, 32'h0);
    rd_chk(8'h40, 32'h0, 32'hffffffff, irf_pkg::RESP_DECERR);
    wr(8'h40, 32'hff, irf_pkg::RESP_DECERR);
    for (int k = 0; k < 9; k++) begin
      capcmp_mode_i <= md_tab[k];
      fire(k);
      rd_chk(irf_pkg::ADDR_FLAGS, {24'h0, ex_tab[k] | 8'h10});
      rd_chk(irf_pkg::ADDR_FLAGS, {24'h0, ex_tab[k] | 8'h10});
      wr(irf_pkg::ADDR_FLAGS, 32'h0);
    end
    serial_tx_empty_i <= 1'b0;
    wr(irf_pkg::ADDR_FLAGS, 32'hff);
    rd_chk(irf_pkg::ADDR_FLAGS, 32'hc7);
    serial_tx_empty_i <= 1'b1;
    // overflow pulse lands in the very cycle the clearing write is applied
    fork
      wr(irf_pkg::ADDR_FLAGS, 32'h0);
      begin
        repeat (2) @(posedge clock_i);
        timer16_overflow_i <= 1'b1;
        @(posedge clock_i);
        timer16_overflow_i <= 1'b0;
      end
    join
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h11);
    // byte lane 0 off: write answered but nothing stored
    s_axi_wstrb <= 4'he;
    wr(irf_pkg::ADDR_FLAGS, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h11);
    wr(irf_pkg::ADDR_RCAUSE, 32'hff);
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h0b);
    pulse_rst(1'b1);
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h0a);
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h10);
    resistor_osc_mode_i <= 1'b1;
    wr(irf_pkg::ADDR_RCAUSE, 32'h03);
    repeat (3) @(posedge clock_i);
    chk({30'h0, osc_fast_o, osc_use_resistor_o}, 32'h0);
    wr(irf_pkg::ADDR_RCAUSE, 32'h0b);
    repeat (3) @(posedge clock_i);
    chk({30'h0, osc_fast_o, osc_use_resistor_o}, 32'h3);
    wr(irf_pkg::ADDR_RCAUSE, 32'h03);
    pulse_rst(1'b0);
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h0b);
    brownout_detector_enable_i <= 1'b0;
    pulse_rst(1'b1);
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h0a, 32'hfffffffe);
    rd_chk(irf_pkg::ADDR_IRQ_STAT, 32'hd7);
    wr(irf_pkg::ADDR_IRQ_MASK, 32'h21);
    rd_chk(irf_pkg::ADDR_IRQ_MASK, 32'h21);
    capcmp_mode_i <= irf_pkg::MODE_CAPTURE;
    fire(3);
    chk({31'h0, irq_o}, 32'h0);
    fire(6);
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(irf_pkg::ADDR_IRQ_STAT, 32'h05);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    serial_rx_full_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h35);
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(irf_pkg::ADDR_IRQ_STAT, 32'h20);
    serial_rx_full_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd_chk(irf_pkg::ADDR_FLAGS, 32'h15);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(irf_pkg::ADDR_RCAUSE, 32'h08);
    print_verdict();
  end
endmodule
